// File: bench/sar_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sar_link_sva #(
  parameter int T_CYC_NS = 500,
  parameter int SCK_HALF = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic conversion_start_line,
  input wire logic sck,
  input wire logic host_to_converter_line,
  input wire logic sdo_drv,
  input wire logic sdo_oe
);
  localparam int CYC = T_CYC_NS / sar_pkg::CLK_NS;
  logic [9:0] since_r, since_nxt, fall_r, fall_nxt, hc_r, hc_nxt, hs_r, hs_nxt;
  // since_r and fall_r saturate, so a long idle gap never wraps into a short one
  always_comb begin
    since_nxt = (since_r == 10'h3ff) ? since_r : since_r + 10'h001;
    fall_nxt  = (fall_r == 10'h3ff) ? fall_r : fall_r + 10'h001;
    if (conversion_start_line && hc_r == 10'h000) since_nxt = 10'h000;
    if (!sck && hs_r != 10'h000) fall_nxt = 10'h000;
    hc_nxt = conversion_start_line ? hc_r + 10'h001 : 10'h000;
    hs_nxt = sck ? hs_r + 10'h001 : 10'h000;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      since_r <= 10'h3ff;
      fall_r  <= 10'h3ff;
      hc_r    <= 10'h000;
      hs_r    <= 10'h000;
    end else begin
      since_r <= since_nxt;
      fall_r  <= fall_nxt;
      hc_r    <= hc_nxt;
      hs_r    <= hs_nxt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_start_gap: assert property (
    $rose(conversion_start_line) |-> since_r >= CYC - 1) else $error("start gap short");
  chk_pulse_len: assert property (
    $fell(conversion_start_line) |-> hc_r == 10'd1 || hc_r == sar_pkg::QUIET1_CYC)
    else $error("start pulse width wrong");
  chk_quiet_first: assert property (
    $rose(sck) |-> since_r >= sar_pkg::QUIET1_CYC - 1 && !$past(conversion_start_line))
    else $error("clock too soon after start");
  chk_quiet_last: assert property (
    $rose(conversion_start_line) |-> fall_r >= sar_pkg::QUIET2_CYC - 1)
    else $error("start too soon after clocking");
  chk_result_time: assert property (
    $rose(sdo_oe) && since_r < 10'd40 |-> since_r >= sar_pkg::T_CONVMN_NS / 10 - 1)
    else $error("result driven before conversion end");
  chk_float_start: assert property (
    $rose(conversion_start_line) |-> ##[1:5] !sdo_oe) else $error("no release on start");
  chk_float_sdi: assert property (
    $rose(host_to_converter_line) |-> ##[1:5] !sdo_oe) else $error("no release on input");
  chk_sdo_shift: assert property (
    $changed(sdo_drv) && $past(sdo_oe) |-> !sck) else $error("output moved with clock high");
  chk_sdi_change: assert property (
    $changed(host_to_converter_line) |-> !sck) else $error("input moved with clock high");
  chk_sck_half: assert property (
    $fell(sck) |-> hs_r == SCK_HALF) else $error("clock high time wrong");
endmodule // sar_link_sva
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int CONVERSION_CYCLE_TIME = 500;
  localparam int HALF = 4;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [15:0] sample_in = 16'h0000;
  wire         hready;
  logic        hreadyout, hresp, conv_busy, sck_q = 1'b0, cnv_q = 1'b0;
  logic [31:0] hrdata;
  logic [7:0]  cfg_o;
  logic [21:0] wsr = 22'h0;
  int          nclk = 0, cyc = 0, n_mismatch = 0, comparisons = 0;
  sar_if lnk ();
  assign hready = hreadyout;
  sar_dev_end sar_dev_end_inst (.lnk(lnk), .mclk(mclk), .rst_b(rst_b), .sample_in(sample_in),
    .conv_busy(conv_busy), .cfg_o(cfg_o));
  sar_host_end #(.T_CYC_NS(CONVERSION_CYCLE_TIME), .SCK_HALF(HALF)) sar_host_end_inst (.lnk(lnk), .mclk(mclk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  sar_link_sva #(.T_CYC_NS(CONVERSION_CYCLE_TIME), .SCK_HALF(HALF)) sar_link_sva_inst (.mclk(mclk),
    .rst_b(rst_b), .conversion_start_line(lnk.conversion_start_line), .sck(lnk.sck),
    .host_to_converter_line(lnk.host_to_converter_line), .sdo_drv(lnk.sdo_drv),
    .sdo_oe(lnk.sdo_oe));
  always #5 mclk = ~mclk;
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Wire monitor: bits taken at the first low sample of the clock
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sck_q <= lnk.sck;
    cnv_q <= lnk.conversion_start_line;
    if (lnk.conversion_start_line && !cnv_q) begin
      nclk <= 0;
      wsr <= 22'h0;
    end else if (sck_q && !lnk.sck) begin
      nclk <= nclk + 1;
      wsr <= {wsr[20:0], lnk.converter_to_host_line};
    end
    if (cyc == 10000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single transfer; the wait has no bound of its own, the cycle ceiling cuts it
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask
  task automatic frame(input logic [31:0] ctl, input logic [15:0] s, input logic [31:0] exp,
                       input logic [31:0] msk, input int nb, input logic won);
    logic [31:0] q;
    sample_in <= s;
    ahb(1'b1, sar_pkg::OFS_CTRL, ctl, q);
    @(posedge conv_busy);
    // Input moves once sampled; the result must not follow it
    sample_in <= ~s;
    q = 32'h0;
    while (q[sar_pkg::STAT_DONE] !== 1'b1) ahb(1'b0, sar_pkg::OFS_STAT, 32'h0, q);
    ahb(1'b1, sar_pkg::OFS_STAT, 32'h2, q);
    ahb(1'b0, sar_pkg::OFS_DATA, 32'h0, q);
    chk(q & msk, exp);
    chk(32'(nclk), 32'(nb));
    if (won) chk({10'h0, wsr} & msk, exp);
    chk({31'h0, lnk.sdo_oe}, 32'h0);
  endtask
  initial begin
    logic [31:0] q;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    ahb(1'b0, sar_pkg::OFS_STAT, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b1, 8'h10, 32'hffff_ffff, q);
    ahb(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    frame(32'h1, 16'ha5c3, 32'ha5c3, 32'hffff, 16, 1'b1);
    ahb(1'b1, sar_pkg::OFS_CMD, {16'h0, sar_pkg::CMD_WR, 8'h6d}, q);
    frame(32'h1, 16'h1234, 32'h0, 32'h0, 16, 1'b0);
    chk({24'h0, cfg_o}, 32'h6d);
    ahb(1'b1, sar_pkg::OFS_CMD, {16'h0, sar_pkg::CMD_RD, 8'h00}, q);
    frame(32'h1, 16'h1234, 32'h6d, 32'hff, 16, 1'b0);
    ahb(1'b1, sar_pkg::OFS_CMD, 32'h0, q);
    frame(32'h3, 16'h8001, {10'h0, 16'h8001, 6'h2d}, 32'h3f_ffff, 22, 1'b1);
    frame(32'h7, 16'h0000, 32'h2d, 32'h3f_ffff, 22, 1'b1);
    frame(32'h7, 16'hffff, {10'h0, 16'hffff, 6'h2d}, 32'h3f_ffff, 22, 1'b1);
    ahb(1'b0, sar_pkg::OFS_CTRL, 32'h0, q);
    chk(q, 32'h6);
    final_report();
  end
endmodule // testbench
`default_nettype wire

// File: design/sar_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
module sar_dev_end #(
  parameter int RES_W = sar_pkg::RES_W
) (
  sar_if.dev                lnk,
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [RES_W-1:0] sample_in,
  output logic                  conv_busy,
  output logic [7:0]            cfg_o
);
  localparam int FW = RES_W + sar_pkg::STAT_W;

  logic [2:0] cnv_s, sck_s, sdi_s;
  logic       cnv_rise, sdi_rise, cnv_fall, sdi_fall, sck_rise, sck_fall;
  logic [5:0] cnt_r, cnt_nxt;
  logic       busy_r, busy_nxt, oe_r, oe_nxt;
  logic [RES_W-1:0] samp_r, samp_nxt;
  logic [FW-1:0]    sr_r, sr_nxt;
  logic [4:0]  bits_r, bits_nxt, rxn_r, rxn_nxt;
  logic [15:0] rx_r, rx_nxt, rx_sh;
  logic [7:0]  cfg_r, cfg_nxt;

  // Three stages: the third only feeds edge detection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnv_s <= 3'h0;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
    end else begin
      cnv_s <= {cnv_s[1:0], lnk.conversion_start_line};
      sck_s <= {sck_s[1:0], lnk.sck};
      sdi_s <= {sdi_s[1:0], lnk.host_to_converter_line};
    end
  end

  assign cnv_rise = cnv_s[1] & ~cnv_s[2];
  assign cnv_fall = ~cnv_s[1] & cnv_s[2];
  assign sdi_rise = sdi_s[1] & ~sdi_s[2];
  assign sdi_fall = ~sdi_s[1] & sdi_s[2];
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign rx_sh    = {rx_r[14:0], sdi_s[1]};

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    samp_nxt = samp_r;
    sr_nxt   = sr_r;
    bits_nxt = bits_r;
    oe_nxt   = oe_r;
    rxn_nxt  = rxn_r;
    rx_nxt   = rx_r;
    cfg_nxt  = cfg_r;
    if (cnv_rise) begin
      samp_nxt = sample_in;                                      // [R17]
      busy_nxt = 1'b1;                                           // [R01]
      cnt_nxt  = 6'(sar_pkg::CONV_CYC - 1);
      rxn_nxt  = 5'h0;
      oe_nxt   = 1'b0;                                           // [R08] [R15]
    end else begin
      if (busy_r) begin
        if (cnt_r == 6'h0) begin
          busy_nxt = 1'b0;
          // No pipeline: this conversion's word is the next frame
          if (cfg_r[sar_pkg::CFG_STAT_BIT]) begin
            sr_nxt   = {samp_r, cfg_r[5:0]};                     // [R12] [R16]
            bits_nxt = 5'(FW);
          end else begin
            sr_nxt   = {samp_r, 6'h00};                          // [R16]
            bits_nxt = 5'(RES_W);
          end
          oe_nxt = ~cnv_s[1] | ~sdi_s[1];                        // [R07]
        end else begin
          cnt_nxt = cnt_r - 6'h1;
        end
      end
      if (sdi_rise) begin
        oe_nxt = 1'b0;                                           // [R08]
      end else if ((cnv_fall | sdi_fall) && bits_r != 5'h0) begin
        oe_nxt = 1'b1;                                           // [R07]
      end
      if (sck_rise) begin
        rx_nxt = rx_sh;                                          // [R10]
        if (rxn_r == 5'd15) begin
          rxn_nxt = 5'h0;
          if (rx_sh[15:8] == sar_pkg::CMD_WR) begin
            cfg_nxt = rx_sh[7:0];
          end
        end else begin
          rxn_nxt = rxn_r + 5'h1;
        end
      end
      if (sck_fall) begin
        if (rxn_r == 5'd8 && rx_r[7:0] == sar_pkg::CMD_RD) begin
          // Register read: the config byte replaces the remaining bits
          sr_nxt   = {cfg_r, {(FW-8){1'b0}}};
          bits_nxt = 5'd8;
          oe_nxt   = 1'b1;
        end else if (bits_r != 5'h0) begin
          sr_nxt   = {sr_r[FW-2:0], 1'b0};                       // [R09]
          bits_nxt = bits_r - 5'h1;
          if (bits_r == 5'h1) begin
            oe_nxt = 1'b0;                                       // [R08]
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= 6'h0;
      busy_r <= 1'b0;
      samp_r <= '0;
      sr_r   <= '0;
      bits_r <= 5'h0;
      oe_r   <= 1'b0;
      rxn_r  <= 5'h0;
      rx_r   <= 16'h0;
      cfg_r  <= sar_pkg::CFG_RST;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      samp_r <= samp_nxt;
      sr_r   <= sr_nxt;
      bits_r <= bits_nxt;
      oe_r   <= oe_nxt;
      rxn_r  <= rxn_nxt;
      rx_r   <= rx_nxt;
      cfg_r  <= cfg_nxt;
    end
  end

  assign lnk.sdo_drv = sr_r[FW-1];
  assign lnk.sdo_oe  = oe_r;
  assign conv_busy   = busy_r;
  assign cfg_o       = cfg_r;
endmodule // sar_dev_end
`default_nettype wire

// File: design/sar_host_end.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// R01: Result ready 270 to 320 ns after start
// R02: Starts spaced by the variant cycle time
// R03: First clock rise 190 ns after start
// R04: Last clock fall 60 ns before start
// R05: Start pulse 10 ns; turbo: quiet1 long
// R06: Full rate needs turbo and fast clock
// R07: Top result bit driven when line falls
// R08: Output floats on rise or last fall
// R09: Output bits change after falling clock
// R10: Input line sampled on rising clock
// R11: Daisy-chain clock period limits, even duty
// R12: Status option appends six status bits
// R13: Plain mode throughput lower than turbo; code spaces starts by CYC_CNT in both modes
// R14: Start line low before register clocking
// R15: Register read ends floating on start rise
// R16: Sixteen-bit straight binary, no latency
// R17: Input sampled at start rising edge
// R18: Host clocks 16 or 22 bits, idles
module sar_host_end #(
  parameter int T_CYC_NS = sar_pkg::T_CYC_NS,
  parameter int SCK_HALF = sar_pkg::SCK_HALF
) (
  sar_if.hst                lnk,
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp
);
  localparam int FW      = sar_pkg::FRAME_W;
  localparam int CYC_CNT = (T_CYC_NS + sar_pkg::CLK_NS - 1) / sar_pkg::CLK_NS;
  localparam int WAIT_CNT = (sar_pkg::CONVMX_CYC > sar_pkg::QUIET1_CYC) ?
                            sar_pkg::CONVMX_CYC : sar_pkg::QUIET1_CYC;

  typedef enum logic [2:0] {SH_IDLE, SH_CNVH, SH_WAIT, SH_SCKL, SH_SCKH, SH_QUIET} sar_st_t;

  sar_st_t st_r, st_nxt;
  logic [1:0]  sdo_s;
  logic [15:0] cnt_r, cnt_nxt, since_r, since_nxt;
  logic [4:0]  n_r, n_nxt;
  logic        cnv_r, cnv_nxt, sck_r, sck_nxt, sdi_r, sdi_nxt;
  logic [15:0] tx_r, tx_nxt, cmd_r, cmd_nxt;
  logic [FW-1:0] rx_r, rx_nxt;
  logic        go_r, go_nxt, sten_r, sten_nxt, turbo_r, turbo_nxt, done_r, done_nxt;
  logic        wr_r, wr_nxt, ap;
  logic [7:0]  wa_r, wa_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        fin;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_s <= 2'h0;
    end else begin
      sdo_s <= {sdo_s[0], lnk.converter_to_host_line};
    end
  end

  assign ap = hsel & hready & htrans[1];

  // Zero-wait slave: reads are decoded in the address phase
  always_comb begin
    wr_nxt = ap & hwrite;
    wa_nxt = ap ? haddr[7:0] : wa_r;
    rd_nxt = 32'h0;
    if (ap && !hwrite) begin
      unique case (haddr[7:0])
        sar_pkg::OFS_CTRL: rd_nxt = {29'h0, turbo_r, sten_r, go_r};
        sar_pkg::OFS_CMD:  rd_nxt = {16'h0, cmd_r};
        sar_pkg::OFS_STAT: rd_nxt = {30'h0, done_r, go_r | (st_r != SH_IDLE)};
        sar_pkg::OFS_DATA: rd_nxt = {{(32-FW){1'b0}}, rx_r};
        default:           rd_nxt = 32'h0;
      endcase
    end
  end

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    since_nxt = (since_r == 16'hffff) ? since_r : since_r + 16'h1;
    n_nxt     = n_r;
    cnv_nxt   = cnv_r;
    sck_nxt   = sck_r;
    sdi_nxt   = sdi_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    go_nxt    = go_r;
    fin       = 1'b0;
    unique case (st_r)
      SH_IDLE: begin
        if (go_r && since_r >= 16'(CYC_CNT)) begin               // [R02] [R13]
          go_nxt    = 1'b0;
          cnv_nxt   = 1'b1;
          since_nxt = 16'h0;
          // Turbo asks for the pulse to last the whole first quiet time
          cnt_nxt   = turbo_r ? 16'(sar_pkg::QUIET1_CYC - 1) :
                                16'(sar_pkg::CNVH_CYC - 1);       // [R05] [R06]
          tx_nxt    = cmd_r;
          // Register words are 16 bits; status bits lengthen a result frame
          n_nxt     = (cmd_r != 16'h0 || !sten_r) ? 5'(sar_pkg::RES_W) : 5'(FW); // [R18]
          st_nxt    = SH_CNVH;
        end
      end
      SH_CNVH: begin
        if (cnt_r == 16'h0) begin
          cnv_nxt = 1'b0;
          st_nxt  = SH_WAIT;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SH_WAIT: begin
        // Waits out the slowest conversion, so quiet1 and the line setup hold too
        if (since_r >= 16'(WAIT_CNT + sar_pkg::SCNV_CYC)) begin   // [R03] [R14]
          sdi_nxt = tx_r[15];
          tx_nxt  = {tx_r[14:0], 1'b0};
          cnt_nxt = 16'(SCK_HALF - 1);
          st_nxt  = SH_SCKL;
        end
      end
      SH_SCKL: begin
        if (cnt_r == 16'h0) begin
          sck_nxt = 1'b1;
          cnt_nxt = 16'(SCK_HALF - 1);                            // [R11]
          st_nxt  = SH_SCKH;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SH_SCKH: begin
        if (cnt_r == 16'h0) begin
          sck_nxt = 1'b0;                                         // [R11]
          rx_nxt  = {rx_r[FW-2:0], sdo_s[1]};                     // [R09]
          sdi_nxt = tx_r[15];
          tx_nxt  = {tx_r[14:0], 1'b0};
          n_nxt   = n_r - 5'h1;
          cnt_nxt = (n_r == 5'h1) ? 16'(sar_pkg::QUIET2_CYC - 1) : 16'(SCK_HALF - 1);
          st_nxt  = (n_r == 5'h1) ? SH_QUIET : SH_SCKL;           // [R18]
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SH_QUIET: begin
        sdi_nxt = 1'b0;
        if (cnt_r == 16'h0) begin
          fin    = 1'b1;                                          // [R04]
          st_nxt = SH_IDLE;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
    endcase
    cmd_nxt   = cmd_r;
    sten_nxt  = sten_r;
    turbo_nxt = turbo_r;
    done_nxt  = done_r;
    if (wr_r) begin
      unique case (wa_r)
        sar_pkg::OFS_CTRL: begin
          go_nxt    = go_nxt | (hwdata[sar_pkg::CTRL_GO] & st_r == SH_IDLE);
          sten_nxt  = hwdata[sar_pkg::CTRL_STEN];
          turbo_nxt = hwdata[sar_pkg::CTRL_TURBO];
        end
        sar_pkg::OFS_CMD:  cmd_nxt = hwdata[15:0];
        sar_pkg::OFS_STAT: done_nxt = done_r & ~hwdata[sar_pkg::STAT_DONE];
        default: ;
      endcase
    end
    // A finishing frame wins over a clear in the same cycle
    if (fin) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= SH_IDLE;
      cnt_r     <= 16'h0;
      since_r   <= 16'hffff;
      n_r       <= 5'h0;
      cnv_r     <= 1'b0;
      sck_r     <= 1'b0;
      sdi_r     <= 1'b0;
      tx_r      <= 16'h0;
      rx_r      <= '0;
      go_r      <= 1'b0;
      cmd_r     <= 16'h0;
      sten_r    <= 1'b0;
      turbo_r   <= 1'b0;
      done_r    <= 1'b0;
      wr_r      <= 1'b0;
      wa_r      <= 8'h0;
      rd_r      <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      since_r   <= since_nxt;
      n_r       <= n_nxt;
      cnv_r     <= cnv_nxt;
      sck_r     <= sck_nxt;
      sdi_r     <= sdi_nxt;
      tx_r      <= tx_nxt;
      rx_r      <= rx_nxt;
      go_r      <= go_nxt;
      cmd_r     <= cmd_nxt;
      sten_r    <= sten_nxt;
      turbo_r   <= turbo_nxt;
      done_r    <= done_nxt;
      wr_r      <= wr_nxt;
      wa_r      <= wa_nxt;
      rd_r      <= rd_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata                     = rd_r;
  assign lnk.conversion_start_line  = cnv_r;
  assign lnk.sck                    = sck_r;
  assign lnk.host_to_converter_line = sdi_r;
endmodule // sar_host_end
`default_nettype wire

// File: design/sar_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sar_if;
  logic conversion_start_line;
  logic sck;
  logic host_to_converter_line;
  logic sdo_drv;
  logic sdo_oe;
  wire  converter_to_host_line;
  // Released line reads low, as through a pull-down
  assign converter_to_host_line = sdo_oe & sdo_drv;
  modport dev (input conversion_start_line, input sck, input host_to_converter_line,
               output sdo_drv, output sdo_oe);
  modport hst (output conversion_start_line, output sck, output host_to_converter_line,
               input converter_to_host_line);
endinterface
`default_nettype wire

// File: design/sar_pkg.sv
package sar_pkg;
  localparam int CLK_NS      = 10;
  localparam int RES_W       = 16;
  localparam int STAT_W      = 6;
  localparam int FRAME_W     = RES_W + STAT_W;
  localparam int CMD_W       = 8;
  localparam int WORD_W      = 16;
  localparam int CNT_W       = 16;
  // Conversion time, typical, minimum and maximum
  localparam int T_CONV_NS   = 290;
  localparam int T_CONVMN_NS = 270;
  localparam int T_CONVMX_NS = 320;
  localparam int CONV_CYC    = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONVMX_CYC  = (T_CONVMX_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CYC_NS    = 500;
  localparam int T_CNVH_NS   = 10;
  localparam int CNVH_CYC    = (T_CNVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_QUIET1_NS = 190;
  localparam int QUIET1_CYC  = (T_QUIET1_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_QUIET2_NS = 60;
  localparam int QUIET2_CYC  = (T_QUIET2_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SCNV_NS   = 6;
  localparam int SCNV_CYC    = (T_SCNV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF    = 4;
  // Register commands carried in the top byte of a host word
  localparam logic [7:0] CMD_WR = 8'h14;
  localparam logic [7:0] CMD_RD = 8'h15;
  localparam int CFG_STAT_BIT = 6;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Host register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_STEN  = 1;
  localparam int CTRL_TURBO = 2;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
endpackage
